// >>> core/ctx_map.vh
// register offsets, field positions, reset values and codes of the context block
`ifndef CTX_MAP_VH
`define CTX_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CTX_OFS_STAT     8'h00
`define CTX_OFS_CTRL_S   8'h04
`define CTX_OFS_CTRL_NS  8'h08
`define CTX_OFS_IRQ_TGT  8'h0C
`define CTX_OFS_FLT_CFG  8'h10
`define CTX_OFS_EVT_STAT 8'h14
`define CTX_OFS_EVT_MASK 8'h18
`define CTX_OFS_RET      8'h1C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTX_STAT_HANDLER 0
`define CTX_STAT_SECURE  1
`define CTX_STAT_PRIV    2
`define CTX_STAT_SP_PROC 3
`define CTX_CTRL_NPRIV   0
`define CTX_CTRL_SPSEL   1
`define CTX_FLT_BUS_NS   0
`define CTX_FLT_HARD_NS  1

// ------------------------------------------------------------
// event bits
// ------------------------------------------------------------
`define CTX_EVT_SECFLT   0
`define CTX_EVT_WR_DENY  1
`define CTX_EVT_SVC      2
`define CTX_EVT_EXC      3
`define CTX_EVT_W        4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CTX_RST_CTRL     2'h0
`define CTX_RST_IRQ_TGT  8'h00
`define CTX_RST_FLT_CFG  2'h0
`define CTX_RST_EVT_MASK 4'h0

// ------------------------------------------------------------
// exception kinds
// ------------------------------------------------------------
`define CTX_EXC_IRQ      3'h0
`define CTX_EXC_SVC      3'h1
`define CTX_EXC_MEMMAN   3'h2
`define CTX_EXC_USAGE    3'h3
`define CTX_EXC_BUS      3'h4
`define CTX_EXC_HARD     3'h5
`define CTX_EXC_SECURE   3'h6

`endif

// >>> core/mode_privilege_security_state.v
// execution context tracker: mode, privilege and security state
//
// What this block does
// - reset enters Secure state
// - banked control register, one copy per state
// - Secure side may reach Non-secure copy
// - per-interrupt target security state setting
// - some faults banked, others target configurable
// - Secure memory reachable only from Secure state
// - state held apart from mode, four state-mode pairs
// - every state runs both modes, both levels
// - reset starts in Thread mode
// - exception return goes to Thread mode
// - any exception enters Handler mode
// - Thread privilege chosen by control register bit
// - Handler mode always privileged
// - control register written only when privileged
// - supervisor call enters privileged handler
// - system resources restricted when unprivileged
//
// Design decisions made here: the address map and the strobed register port.
`include "ctx_map.vh"
`default_nettype none

module mode_privilege_security_state (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        exc_req,
  input  wire [2:0]  exc_kind,
  input  wire [2:0]  exc_irq,
  input  wire        exc_return,
  input  wire        svc_exec,
  input  wire        mem_req,
  input  wire        mem_secure,
  output wire        mem_grant,
  output wire        mem_fault,
  input  wire        sys_req,
  input  wire        sys_secure,
  output wire        sys_grant,
  output wire        mode_handler,
  output wire        state_secure,
  output wire        privileged,
  output wire        sp_process,
  output reg         exc_taken,
  output reg  [2:0]  exc_taken_kind,
  output reg         exc_target_secure,
  output wire        irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg        handler_q;
  reg        handler_d;
  reg        secure_q;
  reg        secure_d;
  reg        ret_secure_q;
  reg        ret_secure_d;
  reg  [1:0] ctrl_s_q;
  reg  [1:0] ctrl_ns_q;
  reg  [7:0] irq_tgt_q;
  reg  [1:0] flt_cfg_q;
  reg  [3:0] evt_mask_q;
  wire [3:0] evt_stat;
  wire [3:0] evt_set;
  wire [3:0] evt_clr;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // pick the control copy of the given security state
  function [1:0] ctrl_of;
    input       sec;
    input [1:0] cs;
    input [1:0] cns;
    begin
      ctrl_of = sec ? cs : cns;
    end
  endfunction

  // privilege of a context
  function priv_of;
    input       hnd;
    input [1:0] ctl;
    begin
      priv_of = hnd | ~ctl[`CTX_CTRL_NPRIV];
    end
  endfunction

  // true when the bus address names the given register
  function is_at;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      is_at = adr == ofs;
    end
  endfunction

  // ------------------------------------------------------------
  // mode and privilege outputs
  // ------------------------------------------------------------
  wire [1:0] ctrl_cur = ctrl_of(secure_q, ctrl_s_q, ctrl_ns_q);

  assign mode_handler = handler_q;
  assign state_secure = secure_q;
  assign privileged   = priv_of(handler_q, ctrl_cur);
  assign sp_process   = ~handler_q & ctrl_cur[`CTX_CTRL_SPSEL];

  // ------------------------------------------------------------
  // access checks
  // ------------------------------------------------------------
  // secure memory only from secure
  assign mem_grant = mem_req & (~mem_secure | secure_q);
  assign mem_fault = mem_req & mem_secure & ~secure_q;
  assign sys_grant = sys_req & privileged & (~sys_secure | secure_q);

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  wire hit_ctrl_s  = is_at(reg_addr, `CTX_OFS_CTRL_S);
  wire hit_ctrl_ns = is_at(reg_addr, `CTX_OFS_CTRL_NS);
  wire hit_irq_tgt = is_at(reg_addr, `CTX_OFS_IRQ_TGT);
  wire hit_flt_cfg = is_at(reg_addr, `CTX_OFS_FLT_CFG);
  wire hit_ret     = is_at(reg_addr, `CTX_OFS_RET);
  wire hit_evt     = is_at(reg_addr, `CTX_OFS_EVT_STAT);
  wire hit_mask    = is_at(reg_addr, `CTX_OFS_EVT_MASK);
  // secure-only settings, return state included
  wire hit_cfg     = hit_irq_tgt | hit_flt_cfg | hit_ret;

  // ------------------------------------------------------------
  // write permission
  // ------------------------------------------------------------
  // secure reaches both copies
  wire bank_ok     = hit_ctrl_ns | (hit_ctrl_s & secure_q);
  wire ctrl_wr     = reg_wr & bank_ok & privileged;
  wire wr_deny     = reg_wr & (hit_ctrl_s | hit_ctrl_ns | hit_cfg) &
                     ~(privileged & (secure_q | hit_ctrl_ns));
  // target settings are secure-only configuration
  wire cfg_wr      = reg_wr & privileged & secure_q;
  wire ret_wr      = cfg_wr & hit_ret;

  // ------------------------------------------------------------
  // banked control copies
  // ------------------------------------------------------------
  // two independent copies
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_s_q  <= `CTX_RST_CTRL;
      ctrl_ns_q <= `CTX_RST_CTRL;
    end else if (ctrl_wr) begin
      if (hit_ctrl_s)
        ctrl_s_q  <= reg_wdata[1:0];
      else
        ctrl_ns_q <= reg_wdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // target settings and event mask
  // ------------------------------------------------------------
  // per interrupt target setting
  always @(posedge ref_clk) begin
    if (rst) begin
      irq_tgt_q <= `CTX_RST_IRQ_TGT;
      flt_cfg_q <= `CTX_RST_FLT_CFG;
    end else if (cfg_wr) begin
      if (hit_irq_tgt)
        irq_tgt_q <= reg_wdata[7:0];
      if (hit_flt_cfg)
        flt_cfg_q <= reg_wdata[1:0];
    end
  end

  always @(posedge ref_clk) begin
    if (rst)
      evt_mask_q <= `CTX_RST_EVT_MASK;
    else if (reg_wr && hit_mask)
      evt_mask_q <= reg_wdata[3:0];
  end

  // ------------------------------------------------------------
  // exception entry and return
  // ------------------------------------------------------------
  reg       take;
  reg [2:0] take_kind;
  reg       take_sec;

  // ------------------------------------------------------------
  // exception target
  // ------------------------------------------------------------
  // target security state of an exception kind
  function tgt_secure;
    input [2:0] kind;
    input [2:0] num;
    input [7:0] itgt;
    input [1:0] fcfg;
    input       cur;
    begin
      case (kind)
        `CTX_EXC_IRQ:    tgt_secure = ~itgt[num];
        `CTX_EXC_BUS:    tgt_secure = ~fcfg[`CTX_FLT_BUS_NS];
        `CTX_EXC_HARD:   tgt_secure = ~fcfg[`CTX_FLT_HARD_NS];
        `CTX_EXC_SECURE: tgt_secure = 1'b1;
        `CTX_EXC_SVC,
        `CTX_EXC_MEMMAN,
        `CTX_EXC_USAGE:  tgt_secure = cur;
        default:         tgt_secure = cur;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // exception selection
  // ------------------------------------------------------------
  always @* begin
    take      = 1'b0;
    take_kind = `CTX_EXC_IRQ;
    take_sec  = secure_q;
    if (mem_fault) begin
      take      = 1'b1;
      take_kind = `CTX_EXC_SECURE;
      take_sec  = 1'b1;
    end else if (exc_req) begin
      take      = 1'b1;
      take_kind = exc_kind;
      take_sec  = tgt_secure(exc_kind, exc_irq, irq_tgt_q,
                             flt_cfg_q, secure_q);
    end else if (svc_exec) begin
      take      = 1'b1;
      take_kind = `CTX_EXC_SVC;
      take_sec  = secure_q;
    end
  end

  // ------------------------------------------------------------
  // context update
  // ------------------------------------------------------------
  always @* begin
    handler_d    = handler_q;
    secure_d     = secure_q;
    ret_secure_d = ret_secure_q;
    // written return state, entry from thread wins
    if (ret_wr)
      ret_secure_d = reg_wdata[0];
    if (take) begin
      handler_d = 1'b1;
      secure_d  = take_sec;
      if (!handler_q)
        ret_secure_d = secure_q;
    end else if (exc_return && handler_q) begin
      handler_d = 1'b0;
      secure_d  = ret_secure_q;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      handler_q    <= 1'b0;
      secure_q     <= 1'b1;
      ret_secure_q <= 1'b1;
    end else begin
      handler_q    <= handler_d;
      secure_q     <= secure_d;
      ret_secure_q <= ret_secure_d;
    end
  end

  // ------------------------------------------------------------
  // exception report
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      exc_taken         <= 1'b0;
      exc_taken_kind    <= `CTX_EXC_IRQ;
      exc_target_secure <= 1'b1;
    end else begin
      exc_taken <= take;
      if (take) begin
        exc_taken_kind    <= take_kind;
        exc_target_secure <= take_sec;
      end
    end
  end

  // ------------------------------------------------------------
  // sticky events and interrupt
  // ------------------------------------------------------------
  assign evt_set[`CTX_EVT_SECFLT]  = mem_fault;
  assign evt_set[`CTX_EVT_WR_DENY] = wr_deny;
  assign evt_set[`CTX_EVT_SVC]     = svc_exec & ~mem_fault & ~exc_req;
  assign evt_set[`CTX_EVT_EXC]     = take;
  assign evt_clr = (reg_wr && hit_evt) ? reg_wdata[3:0] : 4'h0;

  genvar gi;
  generate
    for (gi = 0; gi < `CTX_EVT_W; gi = gi + 1) begin : g_evt
      reg bit_q;
      // set wins over a same-cycle clear
      always @(posedge ref_clk) begin
        if (rst)
          bit_q <= 1'b0;
        else if (evt_set[gi])
          bit_q <= 1'b1;
        else if (evt_clr[gi])
          bit_q <= 1'b0;
      end
      assign evt_stat[gi] = bit_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------
  assign irq = |(evt_stat & evt_mask_q);

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `CTX_OFS_STAT:
            reg_rdata <= {28'h0000000, sp_process, privileged,
                          secure_q, handler_q};
          `CTX_OFS_CTRL_S:
            reg_rdata <= secure_q ? {30'h00000000, ctrl_s_q} :
                                    32'h00000000;
          `CTX_OFS_CTRL_NS:
            reg_rdata <= {30'h00000000, ctrl_ns_q};
          `CTX_OFS_IRQ_TGT:
            reg_rdata <= {24'h000000, irq_tgt_q};
          `CTX_OFS_FLT_CFG:
            reg_rdata <= {30'h00000000, flt_cfg_q};
          `CTX_OFS_EVT_STAT:
            reg_rdata <= {28'h0000000, evt_stat};
          `CTX_OFS_EVT_MASK:
            reg_rdata <= {28'h0000000, evt_mask_q};
          `CTX_OFS_RET:
            reg_rdata <= {31'h00000000, ret_secure_q};
          default:
            reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // mode_privilege_security_state

`default_nettype wire

// >>> dv/ctx_chk.sv
// assertion checker for the context tracker ports
`include "ctx_map.vh"
`default_nettype none
module ctx_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        exc_req,
  input wire logic        exc_return,
  input wire logic        svc_exec,
  input wire logic        mem_req,
  input wire logic        mem_secure,
  input wire logic        mem_grant,
  input wire logic        mem_fault,
  input wire logic        sys_req,
  input wire logic        sys_secure,
  input wire logic        sys_grant,
  input wire logic        mode_handler,
  input wire logic        state_secure,
  input wire logic        privileged,
  input wire logic        exc_taken,
  input wire logic [2:0]  exc_taken_kind,
  input wire logic        exc_target_secure,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence s_take;
    exc_req || svc_exec || mem_fault;
  endsequence
  sequence s_enter;
    mode_handler && privileged && exc_taken;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_RESET: assert property (disable iff (1'b0)
    rst |=> !mode_handler && state_secure && privileged && !irq)
    else $error("context after reset wrong");
  AST_ENTRY: assert property (s_take |=> s_enter)
    else $error("exception did not enter handler");
  AST_RETURN: assert property (
    mode_handler && exc_return && !exc_req && !svc_exec && !mem_fault
    |=> !mode_handler) else $error("return did not reach thread");
  AST_SECFLT: assert property (mem_fault |=> state_secure &&
    exc_target_secure && exc_taken_kind == `CTX_EXC_SECURE)
    else $error("security fault not taken secure");
  AST_SVC: assert property (svc_exec && !exc_req && !mem_fault
    |=> exc_taken_kind == `CTX_EXC_SVC)
    else $error("supervisor call not taken");
  AST_MEM: assert property (mem_fault == (mem_req && mem_secure &&
    !state_secure) && mem_grant == (mem_req && (!mem_secure ||
    state_secure))) else $error("memory gate wrong");
  AST_SYS: assert property (sys_grant == (sys_req && privileged &&
    (!sys_secure || state_secure))) else $error("system gate wrong");
  AST_HND_PRIV: assert property (mode_handler |-> privileged)
    else $error("handler not privileged");
  AST_RDATA: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule // ctx_chk

bind mode_privilege_security_state ctx_chk u_chk (
  .ref_clk, .rst, .reg_rd, .reg_rdata, .exc_req, .exc_return, .svc_exec,
  .mem_req, .mem_secure, .mem_grant, .mem_fault, .sys_req, .sys_secure,
  .sys_grant, .mode_handler, .state_secure, .privileged, .exc_taken,
  .exc_taken_kind, .exc_target_secure, .irq
);
`default_nettype wire

// >>> dv/mode_privilege_security_state_test.sv
// self-checking bench for the context tracker
`include "ctx_map.vh"
`default_nettype none
module mode_privilege_security_state_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, reg_wr, reg_rd, exc_req, exc_return;
  logic        svc_exec, mem_req, mem_secure, sys_req, sys_secure;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0]  exc_kind, exc_irq, exc_taken_kind;
  wire         mem_grant, mem_fault, sys_grant, mode_handler, state_secure;
  wire         privileged, sp_process, exc_taken, exc_target_secure, irq;
  int          err_total = 0;
  int          samples_checked = 0;

  mode_privilege_security_state dut (
    .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .exc_req, .exc_kind, .exc_irq, .exc_return, .svc_exec, .mem_req,
    .mem_secure, .mem_grant, .mem_fault, .sys_req, .sys_secure, .sys_grant,
    .mode_handler, .state_secure, .privileged, .sp_process, .exc_taken,
    .exc_taken_kind, .exc_target_secure, .irq
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic exc(input logic [2:0] k, input logic [2:0] n);
    @(posedge ref_clk);
    exc_req <= 1'b1;
    exc_kind <= k;
    exc_irq <= n;
    @(posedge ref_clk);
    exc_req <= 1'b0;
    #1 chk(exc_taken, 1'b1);
  endtask
  task automatic ret();
    @(posedge ref_clk);
    exc_return <= 1'b1;
    @(posedge ref_clk);
    exc_return <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_priv();
    rd(`CTX_OFS_STAT, 32'h6);
    rd(`CTX_OFS_EVT_MASK, 32'h0);
    wr(`CTX_OFS_CTRL_S, 32'h1);
    rd(`CTX_OFS_STAT, 32'h2);
    @(posedge ref_clk);
    sys_req <= 1'b1;
    #1 chk(sys_grant, 1'b0);
    @(posedge ref_clk);
    sys_req <= 1'b0;
    wr(`CTX_OFS_CTRL_S, 32'h0);
    rd(`CTX_OFS_CTRL_S, 32'h1);
    @(posedge ref_clk);
    svc_exec <= 1'b1;
    @(posedge ref_clk);
    svc_exec <= 1'b0;
    #1 chk(exc_taken_kind, `CTX_EXC_SVC);
    rd(`CTX_OFS_STAT, 32'h7);
    wr(`CTX_OFS_CTRL_S, 32'h0);
    ret();
    rd(`CTX_OFS_STAT, 32'h6);
    rd(`CTX_OFS_EVT_STAT, 32'hE);
    wr(`CTX_OFS_EVT_MASK, 32'h2);
    #1 chk(irq, 1'b1);
    wr(`CTX_OFS_EVT_STAT, 32'hF);
    #1 chk(irq, 1'b0);
  endtask
  task automatic t_bank();
    wr(`CTX_OFS_CTRL_NS, 32'h3);
    wr(`CTX_OFS_CTRL_S, 32'h2);
    rd(`CTX_OFS_CTRL_NS, 32'h3);
    rd(`CTX_OFS_STAT, 32'hE);
    chk(sp_process, 1'b1);
    wr(`CTX_OFS_IRQ_TGT, 32'h08);
    exc(`CTX_EXC_IRQ, 3'h3);
    chk(exc_target_secure, 1'b0);
    rd(`CTX_OFS_STAT, 32'h5);
    chk(sp_process, 1'b0);
    rd(`CTX_OFS_CTRL_S, 32'h0);
    @(posedge ref_clk);
    sys_req <= 1'b1;
    sys_secure <= 1'b1;
    #1 chk(sys_grant, 1'b0);
    @(posedge ref_clk);
    sys_secure <= 1'b0;
    #1 chk(sys_grant, 1'b1);
    @(posedge ref_clk);
    sys_req <= 1'b0;
    mem_req <= 1'b1;
    mem_secure <= 1'b1;
    #1 chk({mem_fault, mem_grant}, 2'b10);
    @(posedge ref_clk);
    mem_req <= 1'b0;
    #1 chk({state_secure, exc_target_secure}, 2'b11);
    ret();
    rd(`CTX_OFS_STAT, 32'hE);
  endtask
  task automatic t_fault();
    wr(`CTX_OFS_FLT_CFG, 32'h1);
    exc(`CTX_EXC_BUS, 3'h0);
    chk(exc_target_secure, 1'b0);
    ret();
    exc(`CTX_EXC_USAGE, 3'h0);
    chk(exc_target_secure, 1'b1);
    ret();
  endtask
  task automatic t_nsec();
    exc(`CTX_EXC_USAGE, 3'h0);
    wr(`CTX_OFS_RET, 32'h0);
    ret();
    rd(`CTX_OFS_STAT, 32'h8);
    rd(`CTX_OFS_RET, 32'h0);
    wr(`CTX_OFS_CTRL_NS, 32'h0);
    rd(`CTX_OFS_CTRL_NS, 32'h3);
    @(posedge ref_clk);
    svc_exec <= 1'b1;
    @(posedge ref_clk);
    svc_exec <= 1'b0;
    #1 chk({state_secure, privileged}, 2'b01);
    ret();
    rd(`CTX_OFS_STAT, 32'h8);
    @(posedge ref_clk);
    mem_req <= 1'b1;
    mem_secure <= 1'b0;
    #1 chk({mem_fault, mem_grant}, 2'b01);
    @(posedge ref_clk);
    mem_req <= 1'b0;
  endtask
  task automatic t_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`CTX_OFS_STAT, 32'h6);
    rd(`CTX_OFS_CTRL_NS, 32'h0);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(50 * 3000);
    err_total++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, exc_req, exc_return, svc_exec} = 5'h0;
    {mem_req, mem_secure, sys_req, sys_secure} = 4'h0;
    {reg_addr, reg_wdata, exc_kind, exc_irq} = 46'h0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_priv();
    t_bank();
    t_fault();
    t_nsec();
    t_reset();
    test_done();
  end
endmodule // mode_privilege_security_state_test
`default_nettype wire
